// *** bench/tb.sv ***
// Self-checking bench for the converter status-flag block.
// Assumes asfl_top with default parameters and the register map of asfl_pkg.
`timescale 1ns/1ps

module tb;

  logic        sys_clk;
  logic        rst;
  logic [31:0] bus_addr;
  logic [15:0] bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [15:0] bus_rdata;
  logic        cal_done;
  logic [2:0]  ch_valid;
  logic [15:0] ch_data;
  logic [2:0]  ch_over;
  logic [2:0]  ch_under;
  logic        fifo_empty_in;
  logic        fifo_full_in;
  logic        fifo_push;
  logic        acc_valid;
  logic [31:0] acc_value;
  logic [4:0]  low_status;
  logic        converter_irq;
  logic        fifo_enable;
  logic [1:0]  acc_cmp_mode;
  logic [7:0]  mode_out;
  logic        reconfig_pulse;
  int          failures;
  int          cmp_count;
  int          cyc = 0;
  logic [31:0] res_addr [3];
  int          err_bit  [3];

  asfl_top i_dut (
    .sys_clk        (sys_clk),
    .rst            (rst),
    .bus_addr       (bus_addr),
    .bus_wdata      (bus_wdata),
    .bus_wr         (bus_wr),
    .bus_rd         (bus_rd),
    .bus_rdata      (bus_rdata),
    .cal_done       (cal_done),
    .cur_valid      (ch_valid[0]),
    .cur_data       (ch_data),
    .cur_over       (ch_over[0]),
    .cur_under      (ch_under[0]),
    .vlt_valid      (ch_valid[1]),
    .vlt_data       (ch_data),
    .vlt_over       (ch_over[1]),
    .vlt_under      (ch_under[1]),
    .tmp_valid      (ch_valid[2]),
    .tmp_data       (ch_data),
    .tmp_over       (ch_over[2]),
    .tmp_under      (ch_under[2]),
    .fifo_empty_in  (fifo_empty_in),
    .fifo_full_in   (fifo_full_in),
    .fifo_push      (fifo_push),
    .acc_valid      (acc_valid),
    .acc_value      (acc_value),
    .low_status     (low_status),
    .converter_irq  (converter_irq),
    .fifo_enable    (fifo_enable),
    .acc_cmp_mode   (acc_cmp_mode),
    .mode_out       (mode_out),
    .reconfig_pulse (reconfig_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // The run is cut short well beyond the fewer than two hundred cycles the sequence needs.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures = failures + 1;
      complete_run();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge sys_clk);
    bus_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic chk_reg(input logic [31:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge sys_clk);
    bus_rd   <= 1'b0;
    #1;
    chk(bus_rdata, exp);
  endtask

  task automatic pulse_ch(input int ch, input logic [15:0] d, input logic ov, input logic un);
    @(posedge sys_clk);
    ch_valid[ch] <= 1'b1;
    ch_data      <= d;
    ch_over[ch]  <= ov;
    ch_under[ch] <= un;
    @(posedge sys_clk);
    ch_valid     <= 3'h0;
    ch_over      <= 3'h0;
    ch_under     <= 3'h0;
  endtask

  task automatic pulse_sig(input int which);
    @(posedge sys_clk);
    if (which == 0) cal_done <= 1'b1;
    if (which == 1) fifo_push <= 1'b1;
    if (which == 2) acc_valid <= 1'b1;
    @(posedge sys_clk);
    cal_done  <= 1'b0;
    fifo_push <= 1'b0;
    acc_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic chk_irq(input logic exp);
    repeat (3) @(posedge sys_clk);
    #1;
    chk({15'h0000, converter_irq}, {15'h0000, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    res_addr = '{asfl_pkg::ASFL_CUR_RES_ADDR, asfl_pkg::ASFL_VLT_RES_ADDR,
                 asfl_pkg::ASFL_TMP_RES_ADDR};
    err_bit  = '{asfl_pkg::ASFL_IERR_BIT, asfl_pkg::ASFL_VERR_BIT, asfl_pkg::ASFL_TERR_BIT};
    failures = 0;   cmp_count = 0;
    rst = 1'b1;     bus_addr = 32'h00000000;   bus_wdata = 16'h0000;
    bus_wr = 1'b0;  bus_rd = 1'b0;   cal_done = 1'b0;   ch_valid = 3'h0;
    ch_data = 16'h0000;   ch_over = 3'h0;   ch_under = 3'h0;
    fifo_empty_in = 1'b0;   fifo_full_in = 1'b0;   fifo_push = 1'b0;
    acc_valid = 1'b0;   acc_value = 32'h00000000;   low_status = 5'h00;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    chk_reg(asfl_pkg::ASFL_STATUS_ADDR, 16'h0000);
    chk_reg(asfl_pkg::ASFL_MASK_ADDR, 16'h0000);
    chk_reg(32'hFFFF05FC, 16'h0000);
    pulse_sig(0);
    chk_reg(asfl_pkg::ASFL_STATUS_ADDR, 16'h8000);
    wr(asfl_pkg::ASFL_STATUS_ADDR, 16'hFFFF);
    chk_reg(asfl_pkg::ASFL_STATUS_ADDR, 16'h8000);
    wr(asfl_pkg::ASFL_MODE_ADDR, 16'h0041);
    #1;
    chk({15'h0000, reconfig_pulse}, 16'h0001);
    chk({8'h00, mode_out}, 16'h0041);
    chk_reg(asfl_pkg::ASFL_STATUS_ADDR, 16'h0000);
    // Each channel: over, under, then an in-range result.
    for (int ch = 0; ch < 3; ch++) begin
      pulse_ch(ch, 16'h1234, 1'b1, 1'b0);
      chk_reg(res_addr[ch], 16'h7FFF);
      chk_reg(asfl_pkg::ASFL_STATUS_ADDR, 16'h0001 << err_bit[ch]);
      pulse_ch(ch, 16'h1234, 1'b0, 1'b1);
      chk_reg(res_addr[ch], 16'h8000);
      pulse_ch(ch, 16'h0123, 1'b0, 1'b0);
      chk_reg(res_addr[ch], 16'h0123);
      chk_reg(asfl_pkg::ASFL_STATUS_ADDR, 16'h0000);
    end
    // Result FIFO flags.
    fifo_empty_in <= 1'b1;
    wr(asfl_pkg::ASFL_CFG_ADDR, 16'h0001);
    #1;
    chk({15'h0000, fifo_enable}, 16'h0001);
    chk_reg(asfl_pkg::ASFL_STATUS_ADDR, 16'h0100);
    wr(asfl_pkg::ASFL_CFG_ADDR, 16'h0000);
    chk_reg(asfl_pkg::ASFL_STATUS_ADDR, 16'h0000);
    fifo_empty_in <= 1'b0;
    fifo_full_in  <= 1'b1;
    wr(asfl_pkg::ASFL_CFG_ADDR, 16'h0001);
    chk_reg(asfl_pkg::ASFL_STATUS_ADDR, 16'h0080);
    pulse_sig(1);
    fifo_full_in  <= 1'b0;
    chk_reg(asfl_pkg::ASFL_STATUS_ADDR, 16'h0280);
    chk_reg(asfl_pkg::ASFL_STATUS_ADDR, 16'h0280);
    wr(asfl_pkg::ASFL_MODE_ADDR, 16'h0000);
    chk_reg(asfl_pkg::ASFL_STATUS_ADDR, 16'h0000);
    fifo_full_in  <= 1'b1;
    pulse_sig(1);
    fifo_full_in  <= 1'b0;
    wr(asfl_pkg::ASFL_CFG_ADDR, 16'h0000);
    chk_reg(asfl_pkg::ASFL_STATUS_ADDR, 16'h0000);
    wr(asfl_pkg::ASFL_CFG_ADDR, 16'h0001);
    chk_reg(asfl_pkg::ASFL_STATUS_ADDR, 16'h0000);
    // Accumulator threshold, strictly greater in magnitude.
    wr(asfl_pkg::ASFL_THR_LO_ADDR, 16'h0100);
    wr(asfl_pkg::ASFL_THR_HI_ADDR, 16'h0000);
    wr(asfl_pkg::ASFL_CFG_ADDR, 16'h0020);
    #1;
    chk({14'h0000, acc_cmp_mode}, 16'h0001);
    acc_value <= 32'h00000100;
    pulse_sig(2);
    chk_reg(asfl_pkg::ASFL_STATUS_ADDR, 16'h0000);
    acc_value <= 32'hFFFFFEFF;
    pulse_sig(2);
    chk_reg(asfl_pkg::ASFL_STATUS_ADDR, 16'h0040);
    wr(asfl_pkg::ASFL_CFG_ADDR, 16'h0000);
    chk_reg(asfl_pkg::ASFL_STATUS_ADDR, 16'h0000);
    wr(asfl_pkg::ASFL_CFG_ADDR, 16'h0060);
    pulse_sig(2);
    chk_reg(asfl_pkg::ASFL_STATUS_ADDR, 16'h0040);
    wr(asfl_pkg::ASFL_MODE_ADDR, 16'h0000);
    chk_reg(asfl_pkg::ASFL_STATUS_ADDR, 16'h0000);
    // Interrupt request from the masked low byte only.
    wr(asfl_pkg::ASFL_MASK_ADDR, 16'h00FF);
    chk_reg(asfl_pkg::ASFL_MASK_ADDR, 16'h00FF);
    low_status <= 5'h01;
    chk_irq(1'b1);
    wr(asfl_pkg::ASFL_MASK_ADDR, 16'h00FE);
    chk_irq(1'b0);
    low_status <= 5'h00;
    wr(asfl_pkg::ASFL_MASK_ADDR, 16'h00FF);
    fifo_empty_in <= 1'b1;
    wr(asfl_pkg::ASFL_CFG_ADDR, 16'h0001);
    pulse_sig(0);
    chk_reg(asfl_pkg::ASFL_STATUS_ADDR, 16'h8100);
    chk_irq(1'b0);
    fifo_full_in <= 1'b1;
    chk_irq(1'b1);
    complete_run();
  end

endmodule

// *** design/asfl_chan.sv ***
// One converter channel: stores each result, clamped on a range error, and keeps the
// channel's range-error flag.
// Assumes the converter gives over and under indications beside each result strobe.
`timescale 1ns/1ps

module asfl_chan #(
  parameter int DATA_W = 16
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              res_valid,
  input  wire logic [DATA_W-1:0] res_data,
  input  wire logic              res_over,
  input  wire logic              res_under,
  output logic      [DATA_W-1:0] result,
  output logic                   range_err
);

  typedef struct packed {
    logic [DATA_W-1:0] result_r;
    logic              err_r;
  } asfl_chan_st_t;

  asfl_chan_st_t st_r;
  asfl_chan_st_t st_nxt;

  generate
    if (DATA_W != 16) begin : g_bad_width
      $error("asfl_chan supports only 16-bit results.");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    if (res_valid) begin
      if (res_over) begin
        st_nxt.result_r = asfl_pkg::ASFL_POS_FS;
      end else if (res_under) begin
        st_nxt.result_r = asfl_pkg::ASFL_NEG_FS;
      end else begin
        st_nxt.result_r = res_data;
      end
      st_nxt.err_r = res_over | res_under;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r.result_r <= asfl_pkg::ASFL_RES_RST;
      st_r.err_r    <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign result    = st_r.result_r;
  assign range_err = st_r.err_r;

  ////////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_clamp_over: assert property (res_valid && res_over |=>
    result == asfl_pkg::ASFL_POS_FS && range_err) else $error("Over-range not clamped.");
  a_clamp_under: assert property (res_valid && !res_over && res_under |=>
    result == asfl_pkg::ASFL_NEG_FS && range_err) else $error("Under-range not clamped.");
  a_err_clear: assert property (res_valid && !res_over && !res_under |=>
    !range_err && result == $past(res_data)) else $error("In-range result mishandled.");
  a_err_hold: assert property (!res_valid |=>
    $stable(range_err) && $stable(result)) else $error("Channel state moved without result.");

endmodule

// *** design/asfl_top.sv ***
// Converter status-flag logic: status register, interrupt mask, mode and configuration
// registers, per-channel result registers and the flags kept on the result FIFO and the
// current accumulator.
// Assumes the FIFO, converters and accumulator sit outside and report synchronously.
//
// Operation
// - calibration finish sets bit 15.
// - mode register write clears calibration flag.
// - temperature out of range sets bit 14.
// - in-range temperature result clears bit 14.
// - voltage range error sets, in-range clears bit 13.
// - current range error sets, in-range clears bit 12.
// - range errors store clamped full-scale codes.
// - FIFO overflow sets and holds bit 9.
// - overflow no interrupt; cleared by disable, reconfigure.
// - overflow reads zero when FIFO disabled.
// - empty bit shows empty FIFO, no interrupt.
// - empty bit reads zero while FIFO disabled.
// - full FIFO sets bit 7.
// - full flag cleared only by disable, reconfigure.
// - accumulator magnitude above threshold sets bit 6.
// - comparator disable or reconfigure clears bit 6.
// - status read-only, resets zero, writes ignored.
// - bits 8 to 15 never interrupt.
// - interrupt is OR of masked bits 0-7.
// - mask shares low bit positions, resets disabled.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps

module asfl_top #(
  parameter int DATA_W = 16,
  parameter int ACC_W  = 32
) (
  input  wire logic                              sys_clk,
  input  wire logic                              rst,
  input  wire logic [31:0]                       bus_addr,
  input  wire logic [DATA_W-1:0]                 bus_wdata,
  input  wire logic                              bus_wr,
  input  wire logic                              bus_rd,
  output logic      [DATA_W-1:0]                 bus_rdata,
  input  wire logic                              cal_done,
  input  wire logic                              cur_valid,
  input  wire logic [DATA_W-1:0]                 cur_data,
  input  wire logic                              cur_over,
  input  wire logic                              cur_under,
  input  wire logic                              vlt_valid,
  input  wire logic [DATA_W-1:0]                 vlt_data,
  input  wire logic                              vlt_over,
  input  wire logic                              vlt_under,
  input  wire logic                              tmp_valid,
  input  wire logic [DATA_W-1:0]                 tmp_data,
  input  wire logic                              tmp_over,
  input  wire logic                              tmp_under,
  input  wire logic                              fifo_empty_in,
  input  wire logic                              fifo_full_in,
  input  wire logic                              fifo_push,
  input  wire logic                              acc_valid,
  input  wire logic [ACC_W-1:0]                  acc_value,
  input  wire logic [asfl_pkg::ASFL_LOW_W-1:0]   low_status,
  output logic                                   converter_irq,
  output logic                                   fifo_enable,
  output logic      [1:0]                        acc_cmp_mode,
  output logic      [7:0]                        mode_out,
  output logic                                   reconfig_pulse
);

  typedef struct packed {
    logic [DATA_W-1:0] rdata_r;
    logic              irq_r;
    logic [7:0]        mask_r;
    logic [7:0]        mode_r;
    logic [7:0]        cfg_r;
    logic [15:0]       thr_lo_r;
    logic [15:0]       thr_hi_r;
    logic              cal_r;
    logic              ovf_r;
    logic              empty_r;
    logic              full_r;
    logic              acc_r;
    logic              reconf_r;
  } asfl_top_st_t;

  asfl_top_st_t st_r;
  asfl_top_st_t st_nxt;

  generate
    if (DATA_W != 16 || ACC_W != 32) begin : g_bad_width
      $error("asfl_top supports only 16-bit data and a 32-bit accumulator.");
    end
  endgenerate

  function automatic logic asfl_hit(input logic [31:0] addr, input logic [31:0] target);
    asfl_hit = (addr == target);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Channels, indexed current, voltage, temperature.
  logic [asfl_pkg::ASFL_NUM_CH-1:0] ch_valid;
  logic [asfl_pkg::ASFL_NUM_CH-1:0] ch_over;
  logic [asfl_pkg::ASFL_NUM_CH-1:0] ch_under;
  logic [asfl_pkg::ASFL_NUM_CH-1:0] ch_err;
  logic [DATA_W-1:0]                ch_data [asfl_pkg::ASFL_NUM_CH];
  logic [DATA_W-1:0]                ch_res  [asfl_pkg::ASFL_NUM_CH];

  assign ch_valid = {tmp_valid, vlt_valid, cur_valid};
  assign ch_over  = {tmp_over, vlt_over, cur_over};
  assign ch_under = {tmp_under, vlt_under, cur_under};
  assign ch_data[asfl_pkg::ASFL_CH_CUR] = cur_data;
  assign ch_data[asfl_pkg::ASFL_CH_VLT] = vlt_data;
  assign ch_data[asfl_pkg::ASFL_CH_TMP] = tmp_data;

  genvar gi;
  generate
    for (gi = 0; gi < asfl_pkg::ASFL_NUM_CH; gi++) begin : g_chan
      asfl_chan #(
        .DATA_W (DATA_W)
      ) u_chan (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .res_valid (ch_valid[gi]),
        .res_data  (ch_data[gi]),
        .res_over  (ch_over[gi]),
        .res_under (ch_under[gi]),
        .result    (ch_res[gi]),
        .range_err (ch_err[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Decode and live status word.
  logic              wr_mode;
  logic              reconfig;
  logic              fifo_en;
  logic              cmp_on;
  logic [ACC_W-1:0]  acc_mag;
  logic [ACC_W-1:0]  acc_thr;
  logic [15:0]       status_now;
  logic              irq_src;

  assign wr_mode  = bus_wr && asfl_hit(bus_addr, asfl_pkg::ASFL_MODE_ADDR);
  assign reconfig = wr_mode;
  assign fifo_en  = st_r.cfg_r[asfl_pkg::ASFL_CFG_FIFO_EN_BIT];
  assign cmp_on   = st_r.cfg_r[asfl_pkg::ASFL_CFG_ACC_HI_BIT:asfl_pkg::ASFL_CFG_ACC_LO_BIT]
                    != 2'h0;
  assign acc_mag  = acc_value[ACC_W-1] ? ACC_W'(~acc_value + 1'b1) : acc_value;
  assign acc_thr  = {st_r.thr_hi_r, st_r.thr_lo_r};
  assign irq_src  = |(status_now[7:0] & st_r.mask_r);

  always_comb begin
    status_now                           = asfl_pkg::ASFL_STATUS_RST;
    status_now[asfl_pkg::ASFL_CAL_BIT]   = st_r.cal_r;
    status_now[asfl_pkg::ASFL_TERR_BIT]  = ch_err[asfl_pkg::ASFL_CH_TMP];
    status_now[asfl_pkg::ASFL_VERR_BIT]  = ch_err[asfl_pkg::ASFL_CH_VLT];
    status_now[asfl_pkg::ASFL_IERR_BIT]  = ch_err[asfl_pkg::ASFL_CH_CUR];
    status_now[asfl_pkg::ASFL_OVF_BIT]   = st_r.ovf_r & fifo_en;
    // The empty copy lags the enable by a cycle, so it is gated here as well.
    status_now[asfl_pkg::ASFL_EMPTY_BIT] = st_r.empty_r & fifo_en;
    status_now[asfl_pkg::ASFL_FULL_BIT]  = st_r.full_r;
    status_now[asfl_pkg::ASFL_ACC_BIT]   = st_r.acc_r;
    status_now[asfl_pkg::ASFL_LOW_W-1:0] = low_status;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    st_nxt          = st_r;
    st_nxt.reconf_r = reconfig;
    // Every set term stays outside the reconfigure clear, so an event in a reconfigure cycle survives.
    st_nxt.cal_r = cal_done | (st_r.cal_r & ~wr_mode);
    st_nxt.ovf_r = (fifo_en & fifo_push & fifo_full_in)
                 | (st_r.ovf_r & fifo_en & ~reconfig);
    st_nxt.full_r = (fifo_en & fifo_full_in)
                  | (st_r.full_r & fifo_en & ~reconfig);
    st_nxt.empty_r = fifo_en & fifo_empty_in;
    st_nxt.acc_r = (cmp_on & acc_valid & (acc_mag > acc_thr))
                 | (st_r.acc_r & cmp_on & ~reconfig);
    // Bits 8 and up are outside the masked byte, so they can never request.
    st_nxt.irq_r = irq_src;

    // Writes; the status address has no write path at all.
    if (bus_wr) begin
      if (asfl_hit(bus_addr, asfl_pkg::ASFL_MASK_ADDR)) begin
        st_nxt.mask_r = bus_wdata[7:0];
      end
      if (wr_mode) begin
        st_nxt.mode_r = bus_wdata[7:0];
      end
      if (asfl_hit(bus_addr, asfl_pkg::ASFL_CFG_ADDR)) begin
        st_nxt.cfg_r = bus_wdata[7:0];
      end
      if (asfl_hit(bus_addr, asfl_pkg::ASFL_THR_LO_ADDR)) begin
        st_nxt.thr_lo_r = bus_wdata;
      end
      if (asfl_hit(bus_addr, asfl_pkg::ASFL_THR_HI_ADDR)) begin
        st_nxt.thr_hi_r = bus_wdata;
      end
    end

    // Read data stands only in the cycle after the strobe; unmapped reads give zero.
    st_nxt.rdata_r = '0;
    if (bus_rd) begin
      case (bus_addr)
        asfl_pkg::ASFL_STATUS_ADDR:  st_nxt.rdata_r = status_now;
        asfl_pkg::ASFL_MASK_ADDR:    st_nxt.rdata_r = {8'h00, st_r.mask_r};
        asfl_pkg::ASFL_MODE_ADDR:    st_nxt.rdata_r = {8'h00, st_r.mode_r};
        asfl_pkg::ASFL_CFG_ADDR:     st_nxt.rdata_r = {8'h00, st_r.cfg_r};
        asfl_pkg::ASFL_CUR_RES_ADDR: st_nxt.rdata_r = ch_res[asfl_pkg::ASFL_CH_CUR];
        asfl_pkg::ASFL_VLT_RES_ADDR: st_nxt.rdata_r = ch_res[asfl_pkg::ASFL_CH_VLT];
        asfl_pkg::ASFL_TMP_RES_ADDR: st_nxt.rdata_r = ch_res[asfl_pkg::ASFL_CH_TMP];
        asfl_pkg::ASFL_THR_LO_ADDR:  st_nxt.rdata_r = st_r.thr_lo_r;
        asfl_pkg::ASFL_THR_HI_ADDR:  st_nxt.rdata_r = st_r.thr_hi_r;
        default:                     st_nxt.rdata_r = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r.rdata_r  <= '0;
      st_r.irq_r    <= 1'b0;
      st_r.mask_r   <= asfl_pkg::ASFL_MASK_RST;
      st_r.mode_r   <= asfl_pkg::ASFL_MODE_RST;
      st_r.cfg_r    <= asfl_pkg::ASFL_CFG_RST;
      st_r.thr_lo_r <= asfl_pkg::ASFL_THR_RST;
      st_r.thr_hi_r <= asfl_pkg::ASFL_THR_RST;
      st_r.cal_r    <= 1'b0;
      st_r.ovf_r    <= 1'b0;
      st_r.empty_r  <= 1'b0;
      st_r.full_r   <= 1'b0;
      st_r.acc_r    <= 1'b0;
      st_r.reconf_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus_rdata      = st_r.rdata_r;
  assign converter_irq  = st_r.irq_r;
  assign fifo_enable    = st_r.cfg_r[asfl_pkg::ASFL_CFG_FIFO_EN_BIT];
  assign acc_cmp_mode   = st_r.cfg_r[asfl_pkg::ASFL_CFG_ACC_HI_BIT:asfl_pkg::ASFL_CFG_ACC_LO_BIT];
  assign mode_out       = st_r.mode_r;
  assign reconfig_pulse = st_r.reconf_r;

  ////////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_status_read;
    bus_rd && bus_addr == asfl_pkg::ASFL_STATUS_ADDR;
  endsequence

  sequence s_status_write;
    bus_wr && bus_addr == asfl_pkg::ASFL_STATUS_ADDR;
  endsequence

  a_cal_set: assert property (cal_done |=> st_r.cal_r)
    else $error("Calibration flag not set.");
  a_cal_clear: assert property (wr_mode && !cal_done |=> !st_r.cal_r)
    else $error("Calibration flag not cleared by mode write.");
  a_ovf_latch: assert property (st_r.ovf_r && fifo_en && !reconfig |=> st_r.ovf_r)
    else $error("Overflow flag dropped.");
  a_ovf_zero: assert property (s_status_read ##0 !fifo_en |=>
    !bus_rdata[asfl_pkg::ASFL_OVF_BIT]) else $error("Overflow read high while disabled.");
  a_empty_off: assert property (!fifo_en |=> !st_r.empty_r)
    else $error("Empty flag high while disabled.");
  a_empty_read: assert property (s_status_read ##0 !fifo_en |=>
    !bus_rdata[asfl_pkg::ASFL_EMPTY_BIT]) else $error("Empty read high while disabled.");
  a_full_hold: assert property (st_r.full_r && fifo_en && !reconfig |=> st_r.full_r)
    else $error("Full flag dropped.");
  a_acc_clear: assert property (!cmp_on |=> !st_r.acc_r)
    else $error("Threshold flag high with comparator off.");
  a_irq_form: assert property (1'b1 |=>
    converter_irq == $past(irq_src))
    else $error("Interrupt not the masked OR of the low byte.");
  a_status_read: assert property (s_status_read |=> bus_rdata == $past(status_now))
    else $error("Status read data wrong.");
  a_rsv_zero: assert property (s_status_read |=>
    bus_rdata[11:10] == 2'h0 && !bus_rdata[5]) else $error("Reserved status bits not zero.");
  a_wr_ignored: assert property (s_status_write ##0 !cal_done |=>
    st_r.cal_r == $past(st_r.cal_r) && st_r.mask_r == $past(st_r.mask_r))
    else $error("Status write changed state.");

endmodule

// *** include/asfl_pkg.sv ***
// Constants for the converter status-flag block: register addresses, flag bit positions,
// configuration fields, reset values and clamp codes.
// Assumes a 16-bit register port addressed by full 32-bit byte addresses.
package asfl_pkg;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Register addresses.
  localparam logic [31:0] ASFL_STATUS_ADDR  = 32'hFFFF0500;
  localparam logic [31:0] ASFL_MASK_ADDR    = 32'hFFFF0504;
  localparam logic [31:0] ASFL_MODE_ADDR    = 32'hFFFF0508;
  localparam logic [31:0] ASFL_CFG_ADDR     = 32'hFFFF050C;
  localparam logic [31:0] ASFL_CUR_RES_ADDR = 32'hFFFF0510;
  localparam logic [31:0] ASFL_VLT_RES_ADDR = 32'hFFFF0514;
  localparam logic [31:0] ASFL_TMP_RES_ADDR = 32'hFFFF0518;
  localparam logic [31:0] ASFL_THR_LO_ADDR  = 32'hFFFF051C;
  localparam logic [31:0] ASFL_THR_HI_ADDR  = 32'hFFFF0520;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Status flag bit positions.
  localparam int ASFL_CAL_BIT   = 15;
  localparam int ASFL_TERR_BIT  = 14;
  localparam int ASFL_VERR_BIT  = 13;
  localparam int ASFL_IERR_BIT  = 12;
  localparam int ASFL_OVF_BIT   = 9;
  localparam int ASFL_EMPTY_BIT = 8;
  localparam int ASFL_FULL_BIT  = 7;
  localparam int ASFL_ACC_BIT   = 6;
  localparam int ASFL_LOW_W     = 5;

  // Configuration register fields.
  localparam int ASFL_CFG_FIFO_EN_BIT = 0;
  localparam int ASFL_CFG_ACC_LO_BIT  = 5;
  localparam int ASFL_CFG_ACC_HI_BIT  = 6;

  // Channel indices.
  localparam int ASFL_CH_CUR = 0;
  localparam int ASFL_CH_VLT = 1;
  localparam int ASFL_CH_TMP = 2;
  localparam int ASFL_NUM_CH = 3;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Reset values and clamp codes.
  localparam logic [15:0] ASFL_STATUS_RST = 16'h0000;
  localparam logic [7:0]  ASFL_MASK_RST   = 8'h00;
  localparam logic [7:0]  ASFL_MODE_RST   = 8'h00;
  localparam logic [7:0]  ASFL_CFG_RST    = 8'h00;
  localparam logic [15:0] ASFL_THR_RST    = 16'h0000;
  localparam logic [15:0] ASFL_RES_RST    = 16'h0000;
  localparam logic [15:0] ASFL_POS_FS     = 16'h7FFF;
  localparam logic [15:0] ASFL_NEG_FS     = 16'h8000;

endpackage
